// ==== pkg/cdid_pkg.sv ====
// Purpose: constants and carrier types for the character display instruction decoder
// Assumes: 100 MHz ref_clk; host port is register_select/read_write_select/data strobes
// Notes  : offsets, positions, cycle counts and the inc, width and glyph table reset values live here
//
// Functional notes
// RULE_01: data access steps address counter by one
// RULE_02: busy_indicator high while operation runs
// RULE_03: clear display fills memory with 20h
// RULE_04: clear loads address zero, unshifts, homes cursor
// RULE_05: clear forces increment, keeps shift bit
// RULE_06: return home zeroes address, unshifts, keeps data
// RULE_07: increment setting picks address step direction
// RULE_08: entry shift moves display on writes
// RULE_09: display control holds on, cursor, blink
// RULE_10: shift command moves without touching data
// RULE_11: select/direction bits decode four shift actions
// RULE_12: two-line cursor wraps after position 40
// RULE_13: both lines shift together, horizontally only
// RULE_14: display shift alone keeps address counter
// RULE_15: mode bit selects graphic or character
// RULE_16: power bit switches internal converter
// RULE_17: width bit picks eight or nibble transfers
// RULE_18: line bit selects one or two lines
// RULE_19: font bit selects 5x8 or 5x10
// RULE_20: function set only after width change
// RULE_21: glyph table bits default zero, 11 unused
// RULE_22: busy ignores all but status read
// RULE_23: cursor and blink bits drive indicators
package cdid_pkg;

   // ------------------------------------------------------------
   // geometry and codes
   // ------------------------------------------------------------
   localparam int          CDID_DDM_DEPTH   = 80;
   localparam logic [6:0]  CDID_LINE_LEN    = 7'h28;
   localparam logic [6:0]  CDID_LINE2_BASE  = 7'h40;
   localparam logic [6:0]  CDID_LINE2_LAST  = 7'h67;
   localparam logic [6:0]  CDID_LINE1_LAST  = 7'h27;
   localparam logic [6:0]  CDID_ONE_LAST    = 7'h4f;
   localparam logic [7:0]  CDID_BLANK_CODE  = 8'h20;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CDID_CLK_NS     = 10;
   localparam int CDID_CLEAR_NS   = 6200000;
   localparam int CDID_CLEAR_CYC  = CDID_CLEAR_NS / CDID_CLK_NS;
   localparam int CDID_SHORT_CYC  = 4;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic       CDID_RST_INC       = 1'b1;
   localparam logic       CDID_RST_WIDTH     = 1'b1;
   localparam logic [1:0] CDID_RST_GLYPH_TBL = 2'b00;

   typedef enum logic [2:0] {
      CDID_IDLE  = 3'b000,
      CDID_EXEC  = 3'b001,
      CDID_CLEAR = 3'b011,
      CDID_DONE  = 3'b010
   } cdid_state_t;

   typedef struct packed {
      logic       inc;
      logic       shift_en;
   } cdid_entry_t;

   typedef struct packed {
      logic       disp_on;
      logic       cursor_on;
      logic       blink_on;
      logic       graphic_mode;
      logic       power_on;
      logic       bus_width_select;
      logic       two_line;
      logic       font_tall;
      logic       glyph_table_sel_hi;
      logic       glyph_table_sel_lo;
   } cdid_ctrl_t;

   typedef struct packed {
      logic       register_select;
      logic       read_write_select;
      logic [7:0] data;
   } cdid_cmd_t;

endpackage : cdid_pkg

// ==== logic/cdid_addr_step.sv ====
// Purpose: next address counter value for one step left or right
// Assumes: address counter holds either display or glyph memory address
// Notes  : wraps line ends in display memory, plain 6-bit wrap in glyph memory
`timescale 1ns/1ps
`default_nettype none
module cdid_addr_step
   import cdid_pkg::*;
(
   // current position
   input  wire logic [6:0] addr,
   input  wire logic       glyph_sel,
   input  wire logic       two_line,
   // direction
   input  wire logic       up,
   // result
   output logic [6:0]      addr_next
);
   wire logic [6:0] plus1  = addr + 7'h01;
   wire logic [6:0] minus1 = addr - 7'h01;
   wire logic [6:0] glyph_next = {1'b0, (up ? plus1[5:0] : minus1[5:0])};
   // two-line: 27h -> 40h, 67h -> 00h and back
   wire logic [6:0] two_up   = (addr == CDID_LINE1_LAST) ? CDID_LINE2_BASE :
                               (addr == CDID_LINE2_LAST) ? 7'h00 : plus1;       // RULE_12
   wire logic [6:0] two_down = (addr == CDID_LINE2_BASE) ? CDID_LINE1_LAST :
                               (addr == 7'h00) ? CDID_LINE2_LAST : minus1;
   wire logic [6:0] one_up   = (addr == CDID_ONE_LAST) ? 7'h00 : plus1;
   wire logic [6:0] one_down = (addr == 7'h00) ? CDID_ONE_LAST : minus1;
   wire logic [6:0] dd_next  = two_line ? (up ? two_up : two_down)
                                        : (up ? one_up : one_down);

   assign addr_next = glyph_sel ? glyph_next : dd_next;                         // RULE_07
endmodule : cdid_addr_step
`default_nettype wire

// ==== logic/cdid_decoder.sv ====
// Purpose: instruction decoder and control state of a character display controller
// Assumes: host strobes are synchronous one-cycle pulses on ref_clk
// Notes  : display memory is flip-flops; status read answers one cycle later
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cdid_decoder #(
   parameter int CLEAR_CYCLES = cdid_pkg::CDID_CLEAR_CYC
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // host command port
   input  wire cdid_pkg::cdid_cmd_t cmd,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic [7:0]             rd_data,
   output logic                   rd_valid,
   // control state
   output cdid_pkg::cdid_ctrl_t   ctrl,
   output cdid_pkg::cdid_entry_t  entry,
   output logic [6:0]             address_counter,
   output logic [6:0]             display_offset,
   output logic                   glyph_sel,
   output logic                   busy_indicator,
   output logic                   nibble_phase
);
   import cdid_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   cdid_state_t  state_reg, state_next;
   cdid_ctrl_t   ctrl_reg;
   cdid_entry_t  entry_reg;
   logic [6:0]   ac_reg;
   logic [6:0]   ofs_reg;
   logic         glyph_sel_reg;
   logic         func_seen_reg;
   logic [22:0]  cnt_reg;
   logic [6:0]   clr_idx_reg;
   logic [7:0]   rd_data_reg;
   logic         rd_valid_reg;
   logic         nib_reg;
   logic [3:0]   nib_hi_reg;
   logic [7:0]   ddm_reg [CDID_DDM_DEPTH];
   logic [7:0]   gm_reg [64];

   // ------------------------------------------------------------
   // nibble assembly
   // ------------------------------------------------------------
   // narrow mode: high nibble first on the upper lines, byte done on second
   wire logic narrow      = ~ctrl_reg.bus_width_select;
   wire logic wr_any      = wr_stb;
   wire logic rd_any      = rd_stb;
   wire logic xfer        = wr_any | rd_any;
   wire logic byte_done   = xfer & (~narrow | nib_reg);                         // RULE_17
   wire logic [7:0] wbyte = narrow ? {nib_hi_reg, cmd.data[7:4]} : cmd.data;    // RULE_17

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire logic is_busy   = (state_reg != CDID_IDLE);
   wire logic ins_wr    = byte_done & wr_any & ~cmd.register_select;
   wire logic dat_wr    = byte_done & wr_any & cmd.register_select;
   wire logic stat_rd   = byte_done & rd_any & ~cmd.register_select;
   wire logic dat_rd    = byte_done & rd_any & cmd.register_select;
   wire logic accept    = ~is_busy;                                             // RULE_22
   wire logic do_ins    = ins_wr & accept;
   wire logic do_dwr    = dat_wr & accept;
   wire logic do_drd    = dat_rd & accept;

   wire logic op_clear  = do_ins & (wbyte == 8'h01);
   wire logic op_home   = do_ins & (wbyte[7:1] == 7'h01);
   wire logic op_entry  = do_ins & (wbyte[7:2] == 6'h01);
   wire logic op_disp   = do_ins & (wbyte[7:3] == 5'h01);
   wire logic op_shift  = do_ins & (wbyte[7:4] == 4'h1) & (wbyte[1:0] == 2'b00);
   wire logic op_mode   = do_ins & (wbyte[7:4] == 4'h1) & (wbyte[1:0] == 2'b11);
   wire logic op_func   = do_ins & (wbyte[7:5] == 3'h1);
   wire logic op_gaddr  = do_ins & (wbyte[7:6] == 2'h1);
   wire logic op_daddr  = do_ins & wbyte[7];

   // later function sets only run when they change the width
   wire logic func_take = op_func &
                          (~func_seen_reg | (wbyte[4] != ctrl_reg.bus_width_select)); // RULE_20

   // ------------------------------------------------------------
   // address stepping
   // ------------------------------------------------------------
   wire logic shift_sc = wbyte[3];
   wire logic shift_rl = wbyte[2];
   wire logic data_acc = do_dwr | do_drd;
   wire logic step_up  = op_shift ? shift_rl : entry_reg.inc;                   // RULE_11
   wire logic [6:0] ac_step;

   cdid_addr_step u_step (
      .addr      (ac_reg),
      .glyph_sel (glyph_sel_reg),
      .two_line  (ctrl_reg.two_line),
      .up        (step_up),
      .addr_next (ac_step)
   );

   // both lines share one offset, so rows only slide sideways
   wire logic disp_shift_wr = do_dwr & entry_reg.shift_en & ~glyph_sel_reg;     // RULE_08
   wire logic disp_shift_cmd = op_shift & shift_sc;                             // RULE_13
   wire logic [6:0] ofs_left  = (ofs_reg == CDID_LINE1_LAST) ? 7'h00 : ofs_reg + 7'h01;
   wire logic [6:0] ofs_right = (ofs_reg == 7'h00) ? CDID_LINE1_LAST : ofs_reg - 7'h01;
   // entry: increment shifts left, decrement shifts right
   wire logic shift_left = disp_shift_cmd ? ~shift_rl : entry_reg.inc;          // RULE_08

   // ------------------------------------------------------------
   // busy sequencer
   // ------------------------------------------------------------
   wire logic cnt_done = (cnt_reg == 23'h000000);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CDID_IDLE: begin
            if (op_clear) begin
               state_next = CDID_CLEAR;
            end else if (do_ins | data_acc) begin
               state_next = CDID_EXEC;
            end
         end
         CDID_EXEC: begin
            if (cnt_done) begin
               state_next = CDID_DONE;
            end
         end
         CDID_CLEAR: begin
            if (cnt_done) begin
               state_next = CDID_DONE;
            end
         end
         CDID_DONE: begin
            state_next = CDID_IDLE;
         end
         default: begin
            state_next = CDID_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= CDID_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 23'h000000;
      end else if (state_reg == CDID_IDLE && op_clear) begin
         cnt_reg <= 23'(CLEAR_CYCLES - 1);
      end else if (state_reg == CDID_IDLE && (do_ins | data_acc)) begin
         cnt_reg <= 23'(CDID_SHORT_CYC - 1);
      end else if (!cnt_done) begin
         cnt_reg <= cnt_reg - 23'h000001;
      end
   end

   // ------------------------------------------------------------
   // pending step, applied when busy drops
   // ------------------------------------------------------------
   logic       step_pend_reg;
   logic [6:0] step_val_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         step_pend_reg <= 1'b0;
         step_val_reg  <= 7'h00;
      end else if (data_acc) begin
         step_pend_reg <= 1'b1;                                                 // RULE_01
         step_val_reg  <= ac_step;
      end else if (state_reg == CDID_DONE) begin
         step_pend_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // address counter and offset
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ac_reg        <= 7'h00;
         glyph_sel_reg <= 1'b0;
      end else if (op_clear | op_home) begin
         ac_reg        <= 7'h00;                                                // RULE_04 RULE_06
         glyph_sel_reg <= 1'b0;
      end else if (op_daddr) begin
         ac_reg        <= wbyte[6:0];
         glyph_sel_reg <= 1'b0;
      end else if (op_gaddr) begin
         ac_reg        <= {1'b0, wbyte[5:0]};
         glyph_sel_reg <= 1'b1;
      end else if (op_shift & ~shift_sc) begin
         ac_reg        <= ac_step;                                              // RULE_11
      end else if (state_reg == CDID_DONE && step_pend_reg) begin
         ac_reg        <= step_val_reg;                                         // RULE_01
      end
      // display shift alone leaves ac_reg as it is                            // RULE_14
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ofs_reg <= 7'h00;
      end else if (op_clear | op_home) begin
         ofs_reg <= 7'h00;                                                      // RULE_04 RULE_06
      end else if (disp_shift_cmd | disp_shift_wr) begin
         ofs_reg <= shift_left ? ofs_left : ofs_right;                          // RULE_13
      end
   end

   // ------------------------------------------------------------
   // control settings
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         entry_reg.inc      <= CDID_RST_INC;
         entry_reg.shift_en <= 1'b0;
      end else if (op_clear) begin
         entry_reg.inc      <= 1'b1;                                            // RULE_05
      end else if (op_entry) begin
         entry_reg.inc      <= wbyte[1];                                        // RULE_07
         entry_reg.shift_en <= wbyte[0];                                        // RULE_08
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg.disp_on   <= 1'b0;
         ctrl_reg.cursor_on <= 1'b0;
         ctrl_reg.blink_on  <= 1'b0;
      end else if (op_disp) begin
         ctrl_reg.disp_on   <= wbyte[2];                                        // RULE_09
         ctrl_reg.cursor_on <= wbyte[1];                                        // RULE_23
         ctrl_reg.blink_on  <= wbyte[0];                                        // RULE_23
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg.graphic_mode <= 1'b0;
         ctrl_reg.power_on     <= 1'b0;
      end else if (op_mode) begin
         ctrl_reg.graphic_mode <= wbyte[3];                                     // RULE_15
         ctrl_reg.power_on     <= wbyte[2];                                     // RULE_16
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg.bus_width_select   <= CDID_RST_WIDTH;
         ctrl_reg.two_line           <= 1'b0;
         ctrl_reg.font_tall          <= 1'b0;
         ctrl_reg.glyph_table_sel_hi <= CDID_RST_GLYPH_TBL[1];                  // RULE_21
         ctrl_reg.glyph_table_sel_lo <= CDID_RST_GLYPH_TBL[0];
         func_seen_reg               <= 1'b0;
      end else if (func_take) begin
         ctrl_reg.bus_width_select   <= wbyte[4];                               // RULE_17
         ctrl_reg.two_line           <= wbyte[3];                               // RULE_18
         ctrl_reg.font_tall          <= wbyte[2];                               // RULE_19
         // 11 is unused; stored as written like any other value
         ctrl_reg.glyph_table_sel_hi <= wbyte[1];                               // RULE_21
         ctrl_reg.glyph_table_sel_lo <= wbyte[0];
         func_seen_reg               <= 1'b1;                                   // RULE_20
      end
   end

   // ------------------------------------------------------------
   // nibble phase
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         nib_reg    <= 1'b0;
         nib_hi_reg <= 4'h0;
      end else if (narrow && xfer) begin
         nib_reg    <= ~nib_reg;                                                // RULE_17
         nib_hi_reg <= cmd.data[7:4];
      end else if (!narrow) begin
         nib_reg    <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // memories
   // ------------------------------------------------------------
   // clear walks one location per cycle, well inside the clear time
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clr_idx_reg <= 7'h00;
      end else if (op_clear) begin
         clr_idx_reg <= 7'h00;
      end else if (state_reg == CDID_CLEAR && clr_idx_reg != 7'(CDID_DDM_DEPTH)) begin
         clr_idx_reg <= clr_idx_reg + 7'h01;
      end
   end

   wire logic [6:0] dd_idx = (ctrl_reg.two_line && ac_reg >= CDID_LINE2_BASE) ?
                             (ac_reg - CDID_LINE2_BASE + CDID_LINE_LEN) : ac_reg;

   genvar gi;
   generate
      for (gi = 0; gi < CDID_DDM_DEPTH; gi++) begin : g_ddm
         always_ff @(posedge ref_clk) begin
            if (state_reg == CDID_CLEAR && clr_idx_reg == 7'(gi)) begin
               ddm_reg[gi] <= CDID_BLANK_CODE;                                  // RULE_03
            end else if (do_dwr && !glyph_sel_reg && dd_idx == 7'(gi)) begin
               ddm_reg[gi] <= wbyte;
            end
         end
      end
      for (gi = 0; gi < 64; gi++) begin : g_gm
         always_ff @(posedge ref_clk) begin
            if (do_dwr && glyph_sel_reg && ac_reg[5:0] == 6'(gi)) begin
               gm_reg[gi] <= wbyte;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   wire logic [7:0] mem_byte  = glyph_sel_reg ? gm_reg[ac_reg[5:0]] :
                                (dd_idx < 7'(CDID_DDM_DEPTH) ? ddm_reg[dd_idx] : 8'h00);
   wire logic [7:0] stat_byte = {is_busy, ac_reg};                              // RULE_02
   wire logic [7:0] rd_full   = cmd.register_select ? mem_byte : stat_byte;
   // narrow: first read returns upper nibble, second lower, on upper lines
   wire logic [7:0] rd_sel    = narrow ? (nib_reg ? {rd_full[3:0], 4'h0}
                                                  : {rd_full[7:4], 4'h0}) : rd_full;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_data_reg  <= 8'h00;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= rd_any;
         if (rd_any && (~cmd.register_select | accept)) begin
            rd_data_reg <= rd_sel;                                              // RULE_22
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   logic busy_out_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_out_reg <= 1'b0;
      end else begin
         busy_out_reg <= (state_next != CDID_IDLE);                             // RULE_02
      end
   end

   assign rd_data         = rd_data_reg;
   assign rd_valid        = rd_valid_reg;
   assign ctrl            = ctrl_reg;
   assign entry           = entry_reg;
   assign address_counter = ac_reg;
   assign display_offset  = ofs_reg;                                            // RULE_10
   assign glyph_sel       = glyph_sel_reg;
   assign busy_indicator  = busy_out_reg;
   assign nibble_phase    = nib_reg;
endmodule : cdid_decoder
`default_nettype wire

// ==== testbench/cdid_decoder_asserts.sv ====
// Purpose: port checks for cdid_decoder
// Assumes: checks the 8-bit bus, plus nibble phase toggling on the 4-bit bus
// Notes  : bound into every cdid_decoder
`timescale 1ns/1ps
`default_nettype none
module cdid_decoder_asserts
   import cdid_pkg::*;
(
   // clock and reset
   input wire logic                  ref_clk,
   input wire logic                  rst,
   // host port
   input wire cdid_pkg::cdid_cmd_t   cmd,
   input wire logic                  wr_stb,
   input wire logic                  rd_stb,
   input wire logic [7:0]            rd_data,
   input wire logic                  rd_valid,
   // state
   input wire cdid_pkg::cdid_ctrl_t  ctrl,
   input wire cdid_pkg::cdid_entry_t entry,
   input wire logic [6:0]            address_counter,
   input wire logic [6:0]            display_offset,
   input wire logic                  glyph_sel,
   input wire logic                  busy_indicator,
   input wire logic                  nibble_phase
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // accepted wide writes
   // ----------------------------------------
   wire logic wide = ctrl.bus_width_select;
   wire logic ins  = wr_stb && !busy_indicator && wide && !cmd.register_select;
   wire logic clr  = ins && cmd.data == 8'h01;
   wire logic dsh  = ins && cmd.data[7:3] == 5'h03 && cmd.data[1:0] == 2'h0;
   // below 27h: no line wrap
   wire logic dwr  = wr_stb && !busy_indicator && wide && cmd.register_select
                     && entry.inc && !glyph_sel && address_counter < 7'h27;
   logic [6:0] step_reg;
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         step_reg <= 7'h00;
      else if (dwr)
         step_reg <= address_counter + 7'h01;
   sequence busy_run;
      busy_indicator [*5] ##1 !busy_indicator;
   endsequence
   a_busy_len: assert property (ins && !clr && cmd.data[7:5] != 3'h1 |=> busy_run)
      else $error("busy span wrong");
   a_addr_step: assert property (dwr |=> busy_run ##0 address_counter == step_reg)
      else $error("address step wrong");
   a_clear_home: assert property (clr |=> address_counter == 7'h00 && display_offset == 7'h00
      && entry.inc && busy_indicator) else $error("clear did not home");
   a_clear_keeps: assert property (clr |=> entry.shift_en == $past(entry.shift_en))
      else $error("clear changed shift");
   a_home_zero: assert property (ins && cmd.data[7:1] == 7'h01 |=> busy_run
      ##0 (address_counter == 7'h00 && display_offset == 7'h00)) else $error("home failed");
   a_shift_keeps: assert property (dsh |=> $stable(address_counter) [*6])
      else $error("shift moved address");
   a_busy_refuse: assert property (wr_stb && busy_indicator |=> $stable(ctrl) && $stable(entry))
      else $error("write taken while busy");
   a_status_read: assert property (rd_stb && !cmd.register_select && wide |=> rd_valid
      && rd_data == {$past(busy_indicator), $past(address_counter)}) else $error("bad status");
   a_nibble_flip: assert property ((wr_stb || rd_stb) && !wide |=> nibble_phase != $past(nibble_phase))
      else $error("nibble phase stuck");
endmodule : cdid_decoder_asserts
bind cdid_decoder cdid_decoder_asserts cdid_chk (.*);
`default_nettype wire

// ==== testbench/cdid_host_model.sv ====
// Purpose: host processor driving the instruction port
// Assumes: strobes launched right after a rising edge
// Notes  : idle data shows inverse of last byte
`timescale 1ns/1ps
`default_nettype none
module cdid_host_model
   import cdid_pkg::*;
(
   // clock
   input wire logic            ref_clk,
   // command port
   output var cdid_pkg::cdid_cmd_t cmd,
   output var logic            wr_stb,
   output var logic            rd_stb,
   input wire logic [7:0]      rd_data
);
   logic narrow = 1'b0;
   initial begin
      cmd = '0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   task automatic strobe(input logic rs, rd, input logic [7:0] d);
      @(posedge ref_clk);
      cmd <= '{register_select: rs, read_write_select: rd, data: d};
      wr_stb <= !rd;
      rd_stb <= rd;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      cmd.data <= ~d;
   endtask : strobe
   task automatic wr(input logic rs, input logic [7:0] d);
      strobe(rs, 1'b0, d);
      if (narrow)
         strobe(rs, 1'b0, {d[3:0], 4'h0});
   endtask : wr
   task automatic rd(input logic rs, output logic [7:0] d);
      strobe(rs, 1'b1, 8'h00);
      #1 d = rd_data;
      if (narrow) begin
         strobe(rs, 1'b1, 8'h00);
         #1 d[3:0] = rd_data[7:4];
      end
   endtask : rd
   task automatic poll();
      logic [7:0] s = 8'h80;
      for (int i = 0; i < 400 && s[7]; i++)
         rd(1'b0, s);
   endtask : poll
endmodule : cdid_host_model
`default_nettype wire

// ==== testbench/test_char_display_instruction_decoder.sv ====
// Purpose: self-checking bench for cdid_decoder
// Assumes: clear shortened to 100 cycles
// Notes  : traffic goes via the host model
`timescale 1ns/1ps
`default_nettype none
module test_char_display_instruction_decoder;
   import cdid_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic wr_stb, rd_stb, rd_valid, glyph_sel, busy_indicator, nibble_phase;
   logic [7:0] rd_data, s;
   logic [6:0] address_counter, display_offset;
   cdid_cmd_t cmd;
   cdid_ctrl_t ctrl;
   cdid_entry_t entry;
   int fail_count = 0, checked = 0;
   always #5 ref_clk = ~ref_clk;
   cdid_decoder #(.CLEAR_CYCLES(100)) cdid_decoder_inst (.*);
   cdid_host_model cdid_host_model_inst (.*);
   task automatic cmp(input string what, input logic [15:0] exp, got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic op(input logic rs, input logic [7:0] d);
      cdid_host_model_inst.wr(rs, d);
      cdid_host_model_inst.poll();
   endtask : op
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      cmp("reset ctrl", 16'h010, 16'(ctrl));
      cmp("reset entry", 16'h2, 16'(entry));
      rst <= 1'b0;
      op(0, 8'h3a);
      cmp("fset", 16'h1a, 16'(ctrl));
      op(0, 8'h34);
      cmp("fset again", 16'h1a, 16'(ctrl));
      for (int i = 0; i < 3; i++) begin
         op(0, 8'h08 | (8'h04 >> i));
         cmp("on/off", 16'(3'h4 >> i), 16'(ctrl[9:7]));
      end
      for (int i = 0; i < 4; i++) begin
         op(0, 8'h13 | 8'(i << 2));
         cmp("mode/power", 16'(i), 16'(ctrl[6:5]));
      end
      op(0, 8'h06);
      repeat (3) op(1, 8'h41);
      cmp("ac up", 16'h3, 16'(address_counter));
      op(0, 8'h14);
      cmp("cursor right", 16'h4, 16'(address_counter));
      op(0, 8'h10);
      cmp("cursor left", 16'h3, 16'(address_counter));
      op(0, 8'h18);
      cmp("shift ac", 16'h3, 16'(address_counter));
      cmp("shifted", 16'h1, 16'(display_offset != 7'h00));
      op(0, 8'h1c);
      cmp("shift back", 16'h0, 16'(display_offset));
      op(0, 8'h05);
      op(1, 8'h42);
      cmp("ac down", 16'h2, 16'(address_counter));
      cmp("entry shift", 16'h1, 16'(display_offset != 7'h00));
      op(0, 8'h02);
      cmp("home", 16'h0, 16'({address_counter, display_offset}));
      repeat (40) op(0, 8'h14);
      cmp("wrap", 16'h40, 16'(address_counter));
      cdid_host_model_inst.wr(0, 8'h0c);
      cdid_host_model_inst.rd(0, s);
      cdid_host_model_inst.wr(0, 8'h08);
      cdid_host_model_inst.poll();
      cmp("busy seen", 16'h1, 16'(s[7]));
      cmp("refused", 16'h4, 16'(ctrl[9:7]));
      op(0, 8'h18);
      op(0, 8'h01);
      cmp("clear", 16'h3, 16'(entry));
      cmp("clear home", 16'h0, 16'({address_counter, display_offset}));
      cdid_host_model_inst.rd(1, s);
      cdid_host_model_inst.poll();
      cmp("blank", 16'h20, 16'(s));
      cdid_host_model_inst.wr(0, 8'h2b);
      cdid_host_model_inst.narrow = 1'b1;
      cdid_host_model_inst.poll();
      cmp("narrow", 16'h0b, 16'(ctrl[4:0]));
      cdid_host_model_inst.wr(0, 8'h3c);
      cdid_host_model_inst.narrow = 1'b0;
      cdid_host_model_inst.poll();
      cmp("wide tall", 16'h1c, 16'(ctrl[4:0]));
      wrap_up();
   end
endmodule : test_char_display_instruction_decoder
`default_nettype wire
